// file: fan_duty_pkg.sv
// Constants shared by the fan duty controller and its tachometer counter
`default_nettype none
package fan_duty_pkg;
  localparam int unsigned CLK_HZ          = 250000000;
  localparam int unsigned LUT_ENTRIES     = 12;
  // Register map
  localparam logic [7:0]  TACH_LOW_ADDR   = 8'h46;
  localparam logic [7:0]  TACH_HIGH_ADDR  = 8'h47;
  localparam logic [7:0]  LUT_BASE_ADDR   = 8'h50;  // Temp at base+2i, duty at base+2i+1
  localparam logic [7:0]  LUT_TEMP_RESET  = 8'hff;
  localparam logic [7:0]  LUT_DUTY_RESET  = 8'h00;
  // Duty scale
  localparam logic [7:0]  DUTY_FULL       = 8'hff;
  localparam logic [7:0]  DUTY_ZERO       = 8'h00;
  localparam logic [7:0]  STEP_FINE       = 8'h01;  // 0.39 percent
  localparam logic [7:0]  STEP_COARSE     = 8'h10;  // 6.25 percent
  localparam logic [7:0]  COARSE_MASK     = 8'hf0;
  // Tachometer reference
  localparam int unsigned TACH_REF_HZ     = 90000;
  localparam int unsigned TACH_DIV        = CLK_HZ / TACH_REF_HZ;
  // PWM: 255 slots per period at 22.5 kHz
  localparam int unsigned PWM_HZ          = 22500;
  localparam int unsigned PWM_SLOTS       = 255;
  localparam int unsigned PWM_DIV         = CLK_HZ / (PWM_HZ * PWM_SLOTS);
  // Smoothing intervals in microseconds
  localparam int unsigned STEP_TIME0_US   = 182000;
  localparam int unsigned STEP_TIME1_US   = 91000;
  localparam int unsigned STEP_TIME2_US   = 46000;
  localparam int unsigned STEP_TIME3_US   = 23000;
  localparam int unsigned STEP_CYC0       = STEP_TIME0_US * (CLK_HZ / 1000000);
  localparam int unsigned STEP_CYC1       = STEP_TIME1_US * (CLK_HZ / 1000000);
  localparam int unsigned STEP_CYC2       = STEP_TIME2_US * (CLK_HZ / 1000000);
  localparam int unsigned STEP_CYC3       = STEP_TIME3_US * (CLK_HZ / 1000000);
endpackage : fan_duty_pkg
`default_nettype wire

// file: tach_link_if.sv
// Interface between the duty controller and the tachometer period counter
`timescale 1ns/1ps
`default_nettype none
interface tach_link_if;
  logic        tach_level;
  logic [15:0] period_count;
  modport counter (input tach_level, output period_count);
  modport user    (output tach_level, input period_count);
endinterface : tach_link_if
`default_nettype wire

// file: tach_period_counter.sv
// Tachometer period counter on a 90 kHz reference tick
`timescale 1ns/1ps
`default_nettype none
module tach_period_counter (
  input  wire logic         clk,
  input  wire logic         nrst,
  tach_link_if.counter      link
);
  logic [11:0] ref_div;
  logic        ref_tick;
  logic        tach_prev;
  logic [15:0] running;

  // Reference tick divider
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_div  <= 12'h000;
      ref_tick <= 1'b0;
    end else if (ref_div == 12'(fan_duty_pkg::TACH_DIV - 1)) begin
      ref_div  <= 12'h000;
      ref_tick <= 1'b1;
    end else begin
      ref_div  <= ref_div + 12'h001;
      ref_tick <= 1'b0;
    end
  end

  // Count ticks between rising edges, latch the total on each edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tach_prev         <= 1'b0;
      running           <= 16'h0000;
      link.period_count <= 16'hffff;
    end else begin
      tach_prev <= link.tach_level;
      if (link.tach_level && !tach_prev) begin
        link.period_count <= running;
        running           <= 16'h0000;
      end else if (ref_tick && running != 16'hffff) begin
        running <= running + 16'h0001;
      end
    end
  end
endmodule : tach_period_counter
`default_nettype wire

// file: lut_fan_duty_controller.sv
// Lookup-table fan duty controller with smoothing, hysteresis and tach readout
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Twelve entries pair a temperature set-point with a duty value.
// - Fine one-in-255 duty steps only when 22.5 kHz high resolution selected.
// - Without smoothing the duty jumps to the new entry value at once.
// - With smoothing the duty climbs one step per programmed interval.
// - Below the lowest set-point the duty is zero.
// - Hold the lower entry's duty until the next set-point is exceeded.
// - Comparison resolution one or half degree; transition one step above entry.
// - On falling temperature every set-point is lowered by the hysteresis.
// - Critical temperature output forces full duty at once, no ramp.
// - Four step intervals: 0.182, 0.091, 0.046 and 0.023 seconds.
// - One interval setting serves every table transition.
// - Step size equals duty resolution: 6.25 or 0.39 percent.
// - Tach period counted in 90 kHz reference ticks.
// - Tach count read as low byte at 0x46, high byte at 0x47.
module lut_fan_duty_controller #(
  parameter int unsigned STEP_CYC0 = fan_duty_pkg::STEP_CYC0,
  parameter int unsigned STEP_CYC1 = fan_duty_pkg::STEP_CYC1,
  parameter int unsigned STEP_CYC2 = fan_duty_pkg::STEP_CYC2,
  parameter int unsigned STEP_CYC3 = fan_duty_pkg::STEP_CYC3
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [8:0] temp_half,          // Remote temperature, 0.5 degree units
  input  wire logic       critical_temp_output,
  input  wire logic       smooth_enable,
  input  wire logic [1:0] step_interval_sel,
  input  wire logic       half_degree_res,
  input  wire logic       high_res_22k5,
  input  wire logic [3:0] hysteresis_deg,
  input  wire logic       tach_in,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] duty_now,
  output logic            pwm_out
);
  localparam int unsigned N = fan_duty_pkg::LUT_ENTRIES;

  logic [7:0]  lut_temp [N];
  logic [7:0]  lut_duty [N];
  logic [3:0]  level;
  logic [3:0]  next_level;
  logic [3:0]  count_rise;
  logic [3:0]  count_fall;
  logic [7:0]  target;
  logic [7:0]  step;
  logic [25:0] interval_cnt;
  logic [25:0] interval_len;
  logic        interval_done;
  logic [7:0]  pwm_pre;
  logic [7:0]  pwm_slot;
  logic [N-1:0] above_rise;
  logic [N-1:0] above_fall;

  tach_link_if tach_link ();
  assign tach_link.tach_level = tach_in;

  tach_period_counter u_tach (
    .clk  (clk),
    .nrst (nrst),
    .link (tach_link.counter)
  );

  // Per-entry storage and threshold compares
  for (genvar i = 0; i < N; i++) begin : g_entry
    logic [9:0] thr;
    logic [9:0] thr_low;
    always_ff @(posedge clk) begin
      if (!nrst) begin
        lut_temp[i] <= fan_duty_pkg::LUT_TEMP_RESET;
        lut_duty[i] <= fan_duty_pkg::LUT_DUTY_RESET;
      end else if (reg_write) begin
        if (reg_addr == fan_duty_pkg::LUT_BASE_ADDR + 8'(2 * i)) begin
          lut_temp[i] <= reg_wdata;
        end else if (reg_addr == fan_duty_pkg::LUT_BASE_ADDR + 8'(2 * i + 1)) begin
          lut_duty[i] <= reg_wdata;
        end
      end
    end
    // Set-point in half degrees plus one resolution step
    assign thr = {1'b0, lut_temp[i], 1'b0} + (half_degree_res ? 10'h001 : 10'h002);
    // Hysteresis clamps at zero so a low set-point never wraps around
    assign thr_low = (thr > {5'h00, hysteresis_deg, 1'b0}) ?
                     thr - {5'h00, hysteresis_deg, 1'b0} : 10'h000;
    assign above_rise[i] = {1'b0, temp_half} >= thr;
    assign above_fall[i] = {1'b0, temp_half} >= thr_low;
  end

  // Count entries passed; ascending table makes this the active level
  always_comb begin
    count_rise = 4'h0;
    count_fall = 4'h0;
    for (int j = 0; j < N; j++) begin
      count_rise = count_rise + {3'h0, above_rise[j]};
      count_fall = count_fall + {3'h0, above_fall[j]};
    end
  end

  // Rising uses plain set-points, falling uses lowered ones
  // Lowered set-points never count fewer entries, so falling only drops the level
  always_comb begin
    if (count_rise >= level) begin
      next_level = count_rise;
    end else if (count_fall < level) begin
      next_level = count_fall;
    end else begin
      next_level = level;
    end
  end

  // Active level register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      level <= 4'h0;
    end else begin
      level <= next_level;
    end
  end

  // Target duty of the active level, zero below the first entry
  // Coarse mode drops the low nibble so targets are whole coarse steps
  always_comb begin
    if (level == 4'h0) begin
      target = fan_duty_pkg::DUTY_ZERO;
    end else begin
      target = lut_duty[level - 4'h1];
    end
    if (!high_res_22k5) begin
      target = target & fan_duty_pkg::COARSE_MASK;
    end
    step = high_res_22k5 ? fan_duty_pkg::STEP_FINE : fan_duty_pkg::STEP_COARSE;
  end

  // One interval selection shared by all transitions
  always_comb begin
    case (step_interval_sel)
      2'd0:    interval_len = 26'(STEP_CYC0 - 1);
      2'd1:    interval_len = 26'(STEP_CYC1 - 1);
      2'd2:    interval_len = 26'(STEP_CYC2 - 1);
      default: interval_len = 26'(STEP_CYC3 - 1);
    endcase
  end

  // Interval elapsed; shared by the timer and the ramp
  assign interval_done = (interval_cnt >= interval_len);

  // Interval timer for smoothing steps
  // Held clear during the override so the first step after release waits a full interval
  always_ff @(posedge clk) begin
    if (!nrst || critical_temp_output || duty_now == target) begin
      interval_cnt <= 26'h0;
    end else if (interval_done) begin
      interval_cnt <= 26'h0;
    end else begin
      interval_cnt <= interval_cnt + 26'h1;
    end
  end

  // Duty update: critical override, jump, or ramp one step
  // After the override the ramp starts back down from full scale
  always_ff @(posedge clk) begin
    if (!nrst) begin
      duty_now <= fan_duty_pkg::DUTY_ZERO;
    end else if (critical_temp_output) begin
      duty_now <= fan_duty_pkg::DUTY_FULL;
    end else if (!smooth_enable) begin
      duty_now <= target;
    end else if (interval_done) begin
      if (duty_now < target) begin
        duty_now <= (target - duty_now > step) ? duty_now + step : target;
      end else if (duty_now > target) begin
        duty_now <= (duty_now - target > step) ? duty_now - step : target;
      end
    end
  end

  // PWM: 255 slots per period; full duty stays high
  // Slot never reaches 255, so the top duty keeps the pin high all period
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_pre  <= 8'h00;
      pwm_slot <= 8'h00;
      pwm_out  <= 1'b0;
    end else begin
      if (pwm_pre == 8'(fan_duty_pkg::PWM_DIV - 1)) begin
        pwm_pre  <= 8'h00;
        pwm_slot <= (pwm_slot == 8'(fan_duty_pkg::PWM_SLOTS - 1)) ? 8'h00 : pwm_slot + 8'h01;
      end else begin
        pwm_pre <= pwm_pre + 8'h01;
      end
      pwm_out <= (pwm_slot < duty_now);
    end
  end

  // Register read port
  // Tach bytes come from the live count; read both while the fan runs steady
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == fan_duty_pkg::TACH_LOW_ADDR) begin
      reg_rdata <= tach_link.period_count[7:0];
    end else if (reg_addr == fan_duty_pkg::TACH_HIGH_ADDR) begin
      reg_rdata <= tach_link.period_count[15:8];
    end else if (reg_addr >= fan_duty_pkg::LUT_BASE_ADDR &&
                 reg_addr < fan_duty_pkg::LUT_BASE_ADDR + 8'(2 * N)) begin
      reg_rdata <= reg_addr[0] ? lut_duty[4'((reg_addr - fan_duty_pkg::LUT_BASE_ADDR) >> 1)]
                               : lut_temp[4'((reg_addr - fan_duty_pkg::LUT_BASE_ADDR) >> 1)];
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : lut_fan_duty_controller
`default_nettype wire

// file: fan_model.sv
// Fan model driving a tach square wave
`timescale 1ns/1ps
`default_nettype none
module fan_model (
  input  wire logic        clk,
  input  wire logic [15:0] half_cyc,
  output logic             tach
);
  logic [15:0] cnt   = 16'h0000;
  logic        level = 1'b0;
  assign tach = level;
  // Toggle every half_cyc clocks, zero stops the rotor
  always @(posedge clk) begin
    if (half_cyc == 16'h0000) begin
      cnt <= 16'h0000;
    end else if (cnt + 16'h0001 < half_cyc) begin
      cnt <= cnt + 16'h0001;
    end else begin
      cnt  <= 16'h0000;
      level <= ~level;
    end
  end
endmodule : fan_model
`default_nettype wire

// file: lut_fan_duty_controller_props.sv
// Port checker for the fan duty controller
`timescale 1ns/1ps
`default_nettype none
module lut_fan_duty_controller_props #(
  parameter int unsigned STEP_CYC0 = 20,
  parameter int unsigned STEP_CYC1 = 15,
  parameter int unsigned STEP_CYC2 = 10,
  parameter int unsigned STEP_CYC3 = 5
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       critical_temp_output,
  input wire logic       smooth_enable,
  input wire logic [1:0] step_interval_sel,
  input wire logic       high_res_22k5,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] duty_now,
  input wire logic       pwm_out
);
  logic [15:0] gap;
  logic [31:0] need;
  // Cycles since the duty last moved
  always_ff @(posedge clk) begin
    if (!nrst) gap <= 16'hffff;
    else if ($changed(duty_now)) gap <= 16'h0001;
    else if (gap != 16'hffff) gap <= gap + 16'h0001;
  end
  // Interval chosen by the select pins
  assign need = (step_interval_sel == 2'h0) ? STEP_CYC0 : (step_interval_sel == 2'h1) ? STEP_CYC1 :
                (step_interval_sel == 2'h2) ? STEP_CYC2 : STEP_CYC3;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_reset; $rose(nrst) |-> duty_now == 8'h00 && reg_rdata == 8'h00 && !pwm_out; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_crit; critical_temp_output |=> duty_now == 8'hff; endproperty
  a_crit: assert property (p_crit) else $error("critical did not force full duty");
  property p_step; $changed(duty_now) && $past(smooth_enable) && !$past(critical_temp_output) |->
    (duty_now > $past(duty_now) ? duty_now - $past(duty_now) : $past(duty_now) - duty_now)
    <= ($past(high_res_22k5) ? 8'h01 : 8'h10); endproperty
  a_step: assert property (p_step) else $error("ramp step too large");
  property p_gap; $changed(duty_now) && $past(smooth_enable) && !$past(critical_temp_output)
    |-> 32'(gap) >= need; endproperty
  a_gap: assert property (p_gap) else $error("ramp step came early");
  property p_coarse; $past(high_res_22k5) == 1'b0 && $past(smooth_enable) == 1'b0 &&
    $past(critical_temp_output) == 1'b0 |-> duty_now[3:0] == 4'h0; endproperty
  a_coarse: assert property (p_coarse) else $error("coarse duty not masked");
  property p_pwm_off; duty_now == 8'h00 |=> !pwm_out; endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm high at zero duty");
  property p_pwm_full; duty_now == 8'hff |=> pwm_out; endproperty
  a_pwm_full: assert property (p_pwm_full) else $error("pwm low at full duty");
  property p_unmapped; reg_addr == 8'h00 |=> reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : lut_fan_duty_controller_props
bind lut_fan_duty_controller lut_fan_duty_controller_props #(.STEP_CYC0(STEP_CYC0),
  .STEP_CYC1(STEP_CYC1), .STEP_CYC2(STEP_CYC2), .STEP_CYC3(STEP_CYC3)) u_props (.clk(clk),
  .nrst(nrst), .critical_temp_output(critical_temp_output), .smooth_enable(smooth_enable),
  .step_interval_sel(step_interval_sel), .high_res_22k5(high_res_22k5), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .duty_now(duty_now), .pwm_out(pwm_out));
`default_nettype wire

// file: tb_lut_fan_duty_controller.sv
// Self-checking bench for the fan duty controller
`timescale 1ns/1ps
`default_nettype none
module tb_lut_fan_duty_controller;
  typedef struct packed {logic [8:0] t; logic h; logic r; logic [7:0] d;} row_type;
  logic        clk, nrst, crit, smooth, hres, hr, wr, tach, pwm;
  logic [1:0]  sel;
  logic [3:0]  hyst;
  logic [8:0]  temp;
  logic [7:0]  addr, wdata, rdata, duty, lo, hi;
  logic [15:0] half;
  int          fails, checked, n, k;
  row_type     rows[9] = '{'{9'd40, 1'b1, 1'b1, 8'h00}, '{9'd41, 1'b1, 1'b1, 8'h13},
    '{9'd41, 1'b0, 1'b1, 8'h00}, '{9'd42, 1'b0, 1'b1, 8'h13}, '{9'd50, 1'b1, 1'b1, 8'h13},
    '{9'd51, 1'b1, 1'b1, 8'h23}, '{9'd51, 1'b1, 1'b0, 8'h20}, '{9'd200, 1'b1, 1'b1, 8'hc3},
    '{9'd200, 1'b1, 1'b0, 8'hc0}};
  lut_fan_duty_controller #(.STEP_CYC0(20), .STEP_CYC1(15), .STEP_CYC2(10), .STEP_CYC3(5)) dut (
    .clk(clk), .nrst(nrst), .temp_half(temp), .critical_temp_output(crit),
    .smooth_enable(smooth), .step_interval_sel(sel), .half_degree_res(hres),
    .high_res_22k5(hr), .hysteresis_deg(hyst), .tach_in(tach), .reg_addr(addr),
    .reg_write(wr), .reg_wdata(wdata), .reg_rdata(rdata), .duty_now(duty), .pwm_out(pwm));
  fan_model u_fan (.clk(clk), .half_cyc(half), .tach(tach));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 d = rdata;
  endtask : rd_reg
  task automatic set_temp(input logic [8:0] t, input logic h, input logic r, input logic [7:0] e);
    @(posedge clk);
    temp <= t; hres <= h; hr <= r;
    repeat (3) @(posedge clk);
    #1 check(16'(duty), 16'(e));
  endtask : set_temp
  task automatic wait_duty(input logic [7:0] e, input int lim);
    for (n = 0; n < lim && duty !== e; n++) begin
      @(posedge clk);
      #1;
    end
    check(16'(duty), 16'(e));
    if (duty !== e) report_and_stop();
  endtask : wait_duty
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Main sequence
  initial begin
    nrst = 1'b0; crit = 1'b0; smooth = 1'b0; hres = 1'b1; hr = 1'b1; wr = 1'b0; sel = 2'h3;
    hyst = 4'h0; temp = 9'h000; addr = 8'h00; wdata = 8'h00; half = 16'h0000;
    fails = 0; checked = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(fan_duty_pkg::TACH_LOW_ADDR, lo);
    rd_reg(fan_duty_pkg::TACH_HIGH_ADDR, hi);
    check({hi, lo}, 16'hffff);
    rd_reg(8'h00, lo);
    check(16'(lo), 16'h0000);
    for (int i = 0; i < 12; i++) begin
      wr_reg(fan_duty_pkg::LUT_BASE_ADDR + 8'(2 * i), 8'd20 + 8'(5 * i));
      wr_reg(fan_duty_pkg::LUT_BASE_ADDR + 8'(2 * i + 1), 8'h13 + 8'(16 * i));
    end
    foreach (rows[j]) set_temp(rows[j].t, rows[j].h, rows[j].r, rows[j].d);
    @(posedge clk);
    hyst <= 4'h2;
    set_temp(9'd61, 1'b1, 1'b1, 8'h33);
    set_temp(9'd60, 1'b1, 1'b1, 8'h33);
    set_temp(9'd56, 1'b1, 1'b1, 8'h23);
    @(posedge clk);
    crit <= 1'b1;
    @(posedge clk);
    #1 check(16'(duty), 16'h00ff);
    @(posedge clk);
    crit <= 1'b0; smooth <= 1'b1;
    repeat (12) @(posedge clk);
    #1 check(16'(duty > 8'hf0), 16'h0001);
    wait_duty(8'h23, 3000);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      sel <= 2'(s); temp <= 9'd61;
      wait_duty(8'h33, 3000);
      @(posedge clk);
      temp <= 9'd56;
      wait_duty(8'h23, 3000);
    end
    @(posedge clk);
    smooth <= 1'b0; hr <= 1'b0; temp <= 9'd55;
    wait_duty(8'h20, 8);
    @(posedge clk);
    smooth <= 1'b1; temp <= 9'd61;
    wait_duty(8'h30, 15);
    // High cycles over one full PWM period at a steady duty
    k = 0;
    repeat (fan_duty_pkg::PWM_SLOTS * fan_duty_pkg::PWM_DIV) begin
      @(posedge clk);
      #1 k = k + ((pwm === 1'b1) ? 1 : 0);
    end
    check(16'(k), 16'(48 * fan_duty_pkg::PWM_DIV));
    @(posedge clk);
    half <= 16'd6943;
    k = 0;
    for (n = 0; n < 50000 && k < 5; n++) begin
      @(posedge clk);
      if (tach !== k[0]) k++;
    end
    check(16'(k), 16'd5);
    if (k < 5) report_and_stop();
    rd_reg(fan_duty_pkg::TACH_LOW_ADDR, lo);
    rd_reg(fan_duty_pkg::TACH_HIGH_ADDR, hi);
    check(16'({hi, lo} >= 16'd4 && {hi, lo} <= 16'd6), 16'h0001);
    n = 5400000 / int'({hi, lo});
    check(16'(n >= 900000 && n <= 1350000), 16'h0001);
    // Mid-run reset clears the duty and the pin and returns the first table entry to its reset values
    @(posedge clk);
    half <= 16'h0000; nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    #1 check(16'(duty), 16'h0000);
    check(16'(pwm), 16'h0000);
    rd_reg(fan_duty_pkg::LUT_BASE_ADDR, lo);
    check(16'(lo), 16'h00ff);
    rd_reg(fan_duty_pkg::LUT_BASE_ADDR + 8'h01, lo);
    check(16'(lo), 16'h0000);
    report_and_stop();
  end
endmodule : tb_lut_fan_duty_controller
`default_nettype wire
